// ---- src/ascs_top.sv ----
// asynchronous / synchronous serial channel with register port and interrupts
//
// Implementation choices: the address map and the strobed register port.
`timescale 1ns/10ps
`default_nettype none
// Operation
// [R1] async transmit and receive run concurrently
// [R2] sync mode sends or receives, not both; with loopback set, a sync transfer both sends and receives the byte
// [R3] programmable baud generator from system clock
// [R4] four interrupt requests: transmit, complete, receive, error
// [R5] start bit, 8/9 data, 1/2 stops
// [R6] wake-up bit marks address frames
// [R7] sync moves 8-bit bytes, clock driven out
// [R8] least significant bit shifted first
// [R9] loopback routes transmit back to receiver
// [R10] parity generated on send, checked on receive
// [R11] missing stop bit flags framing error
// [R12] unread buffer at new arrival flags overrun
// [R13] line idles high, start low, stops high
// [R14] software reads/writes buffers in time
module ascs_top
	import ascs_pkg::*;
(
	// clock and reset
	input  wire logic              clk_in,
	input  wire logic              arst_n_in,
	// register port
	input  wire logic [ADDR_W-1:0] addr_in,
	input  wire logic [DATA_W-1:0] wdata_in,
	input  wire logic              wr_in,
	input  wire logic              rd_in,
	output logic      [DATA_W-1:0] rdata_out,
	// serial pins
	input  wire logic              rxd_in,
	output logic                   txd_out,
	output logic                   sclk_out,
	// interrupts
	output logic      [3:0]        irq_vec_out,
	output logic                   irq_out
);
	typedef enum {TX_IDLE, TX_SHIFT} ascs_tx_e;
	typedef enum {SY_IDLE, SY_LOW, SY_HIGH} ascs_sy_e;

	ascs_rx_if rx ();

	// registers
	logic [15:0] ctrl_r;
	logic [15:0] ctrl_nxt;
	logic [15:0] baud_r;
	logic [15:0] baud_nxt;
	logic [5:0]  mask_r;
	logic [5:0]  mask_nxt;
	logic [5:0]  st_r;
	logic [5:0]  st_nxt;
	logic [8:0]  tbuf_r;
	logic [8:0]  tbuf_nxt;
	logic        tbuf_full_r;
	logic        tbuf_full_nxt;
	logic [8:0]  rbuf_r;
	logic [8:0]  rbuf_nxt;
	logic        rx_full_r;
	logic        rx_full_nxt;
	logic [15:0] rdata_r;
	logic [15:0] rdata_nxt;
	logic        rxd_s1_r;
	logic        rxd_s2_r;
	// async transmitter
	ascs_tx_e    tx_st_r;
	ascs_tx_e    tx_st_nxt;
	logic [12:0] tx_sh_r;
	logic [12:0] tx_sh_nxt;
	logic [3:0]  tx_left_r;
	logic [3:0]  tx_left_nxt;
	logic [3:0]  tx_tcnt_r;
	logic [3:0]  tx_tcnt_nxt;
	logic        txd_r;
	logic        txd_nxt;
	// sync engine
	ascs_sy_e    sy_st_r;
	ascs_sy_e    sy_st_nxt;
	logic [7:0]  sy_sh_r;
	logic [7:0]  sy_sh_nxt;
	logic [2:0]  sy_cnt_r;
	logic [2:0]  sy_cnt_nxt;
	logic        sy_rx_r;
	logic        sy_rx_nxt;
	logic        sy_dout_r;
	logic        sy_dout_nxt;
	logic        sclk_r;
	logic        sclk_nxt;
	// events and decode
	ascs_mode_e  mode;
	logic        tick;
	logic        is_sync;
	logic        loop;
	logic        tx_load;
	logic        tx_done;
	logic        sy_load;
	logic        sy_rstart;
	logic        sy_done;
	logic        rx_accept;
	logic        rx_ev;
	logic [8:0]  rx_word;
	logic        rd_rxd;
	logic [5:0]  st_set;
	logic [5:0]  st_clr;
	logic [5:0]  st_act;
	logic [12:0] frame;
	logic [3:0]  nb;
	logic        par_bit;

	assign mode    = ascs_mode_e'(ctrl_r[1:0]);
	assign is_sync = (mode == ASCS_SYNC);
	assign loop    = ctrl_r[CTL_LOOP];
	assign nb      = ascs_nbits(mode, ctrl_r[CTL_PAR_EN]);

	ascs_brg u_brg ( // R3
		.clk_in    (clk_in),
		.arst_n_in (arst_n_in),
		.reload_in (baud_r),
		.tick_out  (tick)
	);

	// receiver has its own state machine so it never waits on the sender
	assign rx.tick    = tick; // R1
	assign rx.rxd     = loop ? txd_r : rxd_s2_r; // R9
	assign rx.en      = !is_sync && ctrl_r[CTL_REN];
	assign rx.nbits   = nb;
	assign rx.nine    = (mode != ASCS_A8);
	assign rx.par_odd = ctrl_r[CTL_PAR_ODD];

	ascs_rx u_rx (
		.clk_in    (clk_in),
		.arst_n_in (arst_n_in),
		.rx        (rx)
	);

	// async frame image, shifted out from bit 0
	always_comb begin
		par_bit = ascs_parity(tbuf_r, mode != ASCS_A8, ctrl_r[CTL_PAR_ODD]); // R10
		frame   = '1; // R13
		frame[0] = 1'b0;
		frame[8:1] = tbuf_r[7:0]; // R8
		if (mode != ASCS_A8) begin
			frame[9] = tbuf_r[8]; // R6
		end
		if (ctrl_r[CTL_PAR_EN]) begin
			frame[nb] = par_bit;
		end
	end

	// async transmitter
	always_comb begin
		tx_load     = (tx_st_r == TX_IDLE) && tbuf_full_r && !is_sync;
		tx_done     = 1'b0;
		tx_st_nxt   = tx_st_r;
		tx_sh_nxt   = tx_sh_r;
		tx_left_nxt = tx_left_r;
		tx_tcnt_nxt = tx_tcnt_r;
		txd_nxt     = txd_r;
		case (tx_st_r)
			TX_IDLE: begin
				txd_nxt = 1'b1; // R13
				if (tx_load) begin
					txd_nxt     = frame[0];
					tx_sh_nxt   = frame >> 1;
					tx_left_nxt = nb + (ctrl_r[CTL_STOP2] ? 4'h2 : 4'h1); // R5
					tx_tcnt_nxt = 4'h0;
					tx_st_nxt   = TX_SHIFT;
				end
			end
			TX_SHIFT: begin
				if (tick) begin
					tx_tcnt_nxt = tx_tcnt_r + 4'h1;
					if (tx_tcnt_r == OVS_LAST) begin
						if (tx_left_r == 4'h0) begin
							tx_st_nxt = TX_IDLE;
							tx_done   = 1'b1;
							txd_nxt   = 1'b1;
						end else begin
							txd_nxt     = tx_sh_r[0];
							tx_sh_nxt   = {1'b1, tx_sh_r[12:1]};
							tx_left_nxt = tx_left_r - 4'h1;
						end
					end
				end
			end
			default: tx_st_nxt = TX_IDLE;
		endcase
	end

	// sync engine: data changes on falling, samples on rising shift clock
	always_comb begin
		sy_load     = (sy_st_r == SY_IDLE) && is_sync && tbuf_full_r;
		sy_rstart   = (sy_st_r == SY_IDLE) && is_sync && !tbuf_full_r && ctrl_r[CTL_REN]; // R2
		sy_done     = 1'b0;
		sy_st_nxt   = sy_st_r;
		sy_sh_nxt   = sy_sh_r;
		sy_cnt_nxt  = sy_cnt_r;
		sy_rx_nxt   = sy_rx_r;
		sy_dout_nxt = sy_dout_r;
		sclk_nxt    = sclk_r;
		case (sy_st_r)
			SY_IDLE: begin
				sclk_nxt    = 1'b1;
				sy_dout_nxt = 1'b1;
				if (sy_load || sy_rstart) begin
					sy_rx_nxt   = sy_rstart;
					sy_sh_nxt   = tbuf_r[7:0];
					sy_dout_nxt = sy_rstart ? 1'b1 : tbuf_r[0]; // R8
					sy_cnt_nxt  = 3'h0;
					sclk_nxt    = 1'b0;
					sy_st_nxt   = SY_LOW;
				end
			end
			SY_LOW: begin
				if (tick) begin
					sclk_nxt  = 1'b1;
					sy_sh_nxt = {loop ? sy_dout_r : rxd_s2_r, sy_sh_r[7:1]}; // R9
					sy_st_nxt = SY_HIGH;
				end
			end
			SY_HIGH: begin
				if (tick) begin
					if (sy_cnt_r == SYNC_LAST) begin // R7
						sy_done     = 1'b1;
						sy_dout_nxt = 1'b1;
						sy_st_nxt   = SY_IDLE;
					end else begin
						sy_cnt_nxt  = sy_cnt_r + 3'h1;
						sclk_nxt    = 1'b0;
						sy_dout_nxt = sy_rx_r ? 1'b1 : sy_sh_r[0];
						sy_st_nxt   = SY_LOW;
					end
				end
			end
			default: sy_st_nxt = SY_IDLE;
		endcase
	end

	// registers, buffers and status
	always_comb begin
		rd_rxd    = rd_in && (addr_in == OFS_RXD);
		rx_accept = rx.done && (!ctrl_r[CTL_WAKE_ONLY] || mode != ASCS_A8W || rx.data[8]); // R6
		rx_ev     = (!is_sync && rx_accept) || (sy_done && (sy_rx_r || loop));
		rx_word   = is_sync ? {1'b0, sy_sh_r} : rx.data;
		st_set    = 6'h00;
		st_set[ST_TBE]  = tx_load || sy_load;
		st_set[ST_TC]   = tx_done || (sy_done && !sy_rx_r);
		st_set[ST_RX]   = rx_ev;
		st_set[ST_PERR] = !is_sync && rx_accept && ctrl_r[CTL_PAR_EN] && rx.perr; // R10
		st_set[ST_FERR] = !is_sync && rx_accept && ctrl_r[CTL_FRM_CHK] && rx.ferr; // R11
		st_set[ST_OERR] = rx_ev && rx_full_r && !rd_rxd; // R12
		st_clr    = (wr_in && addr_in == OFS_STAT) ? wdata_in[ST_W-1:0] : 6'h00;
		st_nxt    = (st_r & ~st_clr) | st_set;
		ctrl_nxt  = ctrl_r;
		baud_nxt  = baud_r;
		mask_nxt  = mask_r;
		tbuf_nxt  = tbuf_r;
		tbuf_full_nxt = tbuf_full_r && !(tx_load || sy_load);
		rbuf_nxt  = rbuf_r;
		rx_full_nxt = rx_full_r && !rd_rxd;
		if (sy_done && sy_rx_r) begin
			ctrl_nxt[CTL_REN] = 1'b0;
		end
		if (wr_in) begin
			case (addr_in)
				OFS_CTRL: ctrl_nxt = wdata_in;
				OFS_BAUD: baud_nxt = wdata_in;
				OFS_MASK: mask_nxt = wdata_in[ST_W-1:0];
				OFS_TXD: begin
					tbuf_nxt      = wdata_in[8:0]; // R14
					tbuf_full_nxt = 1'b1;
				end
				default: ;
			endcase
		end
		if (rx_ev) begin
			rbuf_nxt    = rx_word;
			rx_full_nxt = 1'b1;
		end
		rdata_nxt = 16'h0000;
		if (rd_in) begin
			case (addr_in)
				OFS_CTRL:  rdata_nxt = ctrl_r;
				OFS_BAUD:  rdata_nxt = baud_r;
				OFS_TXD:   rdata_nxt = {7'h00, tbuf_r};
				OFS_RXD:   rdata_nxt = {7'h00, rbuf_r};
				OFS_STAT:  rdata_nxt = {10'h000, st_r};
				OFS_MASK:  rdata_nxt = {10'h000, mask_r};
				OFS_STATE: rdata_nxt = {12'h000, tbuf_full_r, rx_full_r, tx_st_r != TX_IDLE, sy_st_r != SY_IDLE};
				default:   rdata_nxt = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			ctrl_r      <= CTRL_RST;
			baud_r      <= BAUD_RST;
			mask_r      <= MASK_RST;
			st_r        <= STAT_RST;
			tbuf_r      <= 9'h000;
			tbuf_full_r <= 1'b0;
			rbuf_r      <= 9'h000;
			rx_full_r   <= 1'b0;
			rdata_r     <= 16'h0000;
			rxd_s1_r    <= 1'b1;
			rxd_s2_r    <= 1'b1;
			tx_st_r     <= TX_IDLE;
			tx_sh_r     <= 13'h1fff;
			tx_left_r   <= 4'h0;
			tx_tcnt_r   <= 4'h0;
			txd_r       <= 1'b1;
			sy_st_r     <= SY_IDLE;
			sy_sh_r     <= 8'h00;
			sy_cnt_r    <= 3'h0;
			sy_rx_r     <= 1'b0;
			sy_dout_r   <= 1'b1;
			sclk_r      <= 1'b1;
		end else begin
			ctrl_r      <= ctrl_nxt;
			baud_r      <= baud_nxt;
			mask_r      <= mask_nxt;
			st_r        <= st_nxt;
			tbuf_r      <= tbuf_nxt;
			tbuf_full_r <= tbuf_full_nxt;
			rbuf_r      <= rbuf_nxt;
			rx_full_r   <= rx_full_nxt;
			rdata_r     <= rdata_nxt;
			rxd_s1_r    <= rxd_in;
			rxd_s2_r    <= rxd_s1_r;
			tx_st_r     <= tx_st_nxt;
			tx_sh_r     <= tx_sh_nxt;
			tx_left_r   <= tx_left_nxt;
			tx_tcnt_r   <= tx_tcnt_nxt;
			txd_r       <= txd_nxt;
			sy_st_r     <= sy_st_nxt;
			sy_sh_r     <= sy_sh_nxt;
			sy_cnt_r    <= sy_cnt_nxt;
			sy_rx_r     <= sy_rx_nxt;
			sy_dout_r   <= sy_dout_nxt;
			sclk_r      <= sclk_nxt;
		end
	end

	assign st_act         = st_r & mask_r;
	assign irq_vec_out[0] = st_act[ST_TBE]; // R4
	assign irq_vec_out[1] = st_act[ST_TC];
	assign irq_vec_out[2] = st_act[ST_RX];
	assign irq_vec_out[3] = |st_act[ST_OERR:ST_PERR];
	assign irq_out        = |irq_vec_out;
	assign rdata_out      = rdata_r;
	assign txd_out        = is_sync ? sy_dout_r : txd_r;
	assign sclk_out       = sclk_r;
endmodule
`default_nettype wire

// ---- src/ascs_pkg.sv ----
// constants, types and helpers shared by the serial channel design
package ascs_pkg;
	localparam int DATA_W = 16;
	localparam int ADDR_W = 3;

	// register offsets
	localparam logic [2:0] OFS_CTRL  = 3'h0;
	localparam logic [2:0] OFS_BAUD  = 3'h1;
	localparam logic [2:0] OFS_TXD   = 3'h2;
	localparam logic [2:0] OFS_RXD   = 3'h3;
	localparam logic [2:0] OFS_STAT  = 3'h4;
	localparam logic [2:0] OFS_MASK  = 3'h5;
	localparam logic [2:0] OFS_STATE = 3'h6;

	// control field positions (mode occupies bits 1:0)
	localparam int CTL_STOP2     = 2;
	localparam int CTL_PAR_EN    = 3;
	localparam int CTL_PAR_ODD   = 4;
	localparam int CTL_FRM_CHK   = 5;
	localparam int CTL_LOOP      = 6;
	localparam int CTL_REN       = 7;
	localparam int CTL_WAKE_ONLY = 8;

	// status / mask bit positions
	localparam int ST_TBE  = 0;
	localparam int ST_TC   = 1;
	localparam int ST_RX   = 2;
	localparam int ST_PERR = 3;
	localparam int ST_FERR = 4;
	localparam int ST_OERR = 5;
	localparam int ST_W    = 6;

	// reset values
	localparam logic [15:0] CTRL_RST = 16'h0000;
	localparam logic [15:0] BAUD_RST = 16'h0000;
	localparam logic [5:0]  MASK_RST = 6'h00;
	localparam logic [5:0]  STAT_RST = 6'h00;

	// bit timing in baud ticks
	localparam logic [3:0] OVS_MID   = 4'h7;
	localparam logic [3:0] OVS_LAST  = 4'hf;
	localparam logic [2:0] SYNC_LAST = 3'h7;

	typedef enum logic [1:0] {ASCS_SYNC, ASCS_A8, ASCS_A9, ASCS_A8W} ascs_mode_e;

	// parity over 8 or 9 data bits, even unless odd is set
	function automatic logic ascs_parity(input logic [8:0] d, input logic nine, input logic odd);
		return (^d[7:0]) ^ (nine & d[8]) ^ odd;
	endfunction

	// data bits plus ninth bit plus parity bit of an asynchronous frame
	function automatic logic [3:0] ascs_nbits(input ascs_mode_e m, input logic par_en);
		return 4'h8 + {3'h0, m != ASCS_A8} + {3'h0, par_en};
	endfunction
endpackage

// ---- src/ascs_rx_if.sv ----
// link between the channel core and its asynchronous receiver
`timescale 1ns/10ps
`default_nettype none
interface ascs_rx_if;
	logic       tick;
	logic       rxd;
	logic       en;
	logic [3:0] nbits;
	logic       nine;
	logic       par_odd;
	logic       done;
	logic [8:0] data;
	logic       perr;
	logic       ferr;

	modport ctl (output tick, rxd, en, nbits, nine, par_odd, input done, data, perr, ferr);
	modport rcv (input tick, rxd, en, nbits, nine, par_odd, output done, data, perr, ferr);
endinterface
`default_nettype wire

// ---- src/ascs_brg.sv ----
// baud rate tick generator, one tick every reload+1 clocks
`timescale 1ns/10ps
`default_nettype none
module ascs_brg (
	// clock and reset
	input  wire logic        clk_in,
	input  wire logic        arst_n_in,
	// control
	input  wire logic [15:0] reload_in,
	// tick
	output logic             tick_out
);
	logic [15:0] cnt_r;
	logic [15:0] cnt_nxt;
	logic        tick_r;
	logic        tick_nxt;

	always_comb begin
		tick_nxt = 1'b0;
		cnt_nxt  = cnt_r - 16'h0001;
		if (cnt_r == 16'h0000) begin
			tick_nxt = 1'b1;
			cnt_nxt  = reload_in;
		end
	end

	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			cnt_r  <= 16'h0000;
			tick_r <= 1'b0;
		end else begin
			cnt_r  <= cnt_nxt;
			tick_r <= tick_nxt;
		end
	end

	assign tick_out = tick_r;
endmodule
`default_nettype wire

// ---- src/ascs_rx.sv ----
// asynchronous receiver, 16 ticks per bit, samples mid bit
`timescale 1ns/10ps
`default_nettype none
module ascs_rx
	import ascs_pkg::*;
(
	// clock and reset
	input  wire logic clk_in,
	input  wire logic arst_n_in,
	// core link
	ascs_rx_if.rcv    rx
);
	typedef enum {R_IDLE, R_START, R_DATA, R_STOP} ascs_rst_e;

	ascs_rst_e  st_r;
	ascs_rst_e  st_nxt;
	logic [3:0] tcnt_r;
	logic [3:0] tcnt_nxt;
	logic [3:0] bcnt_r;
	logic [3:0] bcnt_nxt;
	logic [9:0] sh_r;
	logic [9:0] sh_nxt;
	logic       done_r;
	logic       done_nxt;
	logic       ferr_r;
	logic       ferr_nxt;

	always_comb begin
		st_nxt   = st_r;
		tcnt_nxt = tcnt_r;
		bcnt_nxt = bcnt_r;
		sh_nxt   = sh_r;
		done_nxt = 1'b0;
		ferr_nxt = ferr_r;
		case (st_r)
			R_IDLE: begin
				if (rx.en && !rx.rxd) begin
					st_nxt   = R_START;
					tcnt_nxt = 4'h0;
				end
			end
			R_START: begin
				if (rx.tick) begin
					tcnt_nxt = tcnt_r + 4'h1;
					if (tcnt_r == OVS_MID) begin
						// glitch shorter than half a bit is not a start
						st_nxt   = rx.rxd ? R_IDLE : R_DATA;
						tcnt_nxt = 4'h0;
						bcnt_nxt = 4'h0;
						sh_nxt   = 10'h3ff;
					end
				end
			end
			R_DATA: begin
				if (rx.tick) begin
					tcnt_nxt = tcnt_r + 4'h1;
					if (tcnt_r == OVS_LAST) begin
						sh_nxt[bcnt_r] = rx.rxd; // R8
						bcnt_nxt       = bcnt_r + 4'h1;
						if (bcnt_r == rx.nbits - 4'h1) begin
							st_nxt = R_STOP;
						end
					end
				end
			end
			R_STOP: begin
				if (rx.tick) begin
					tcnt_nxt = tcnt_r + 4'h1;
					if (tcnt_r == OVS_LAST) begin
						done_nxt = 1'b1;
						ferr_nxt = !rx.rxd; // R11
						st_nxt   = R_IDLE;
					end
				end
			end
			default: st_nxt = R_IDLE;
		endcase
	end

	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			st_r   <= R_IDLE;
			tcnt_r <= 4'h0;
			bcnt_r <= 4'h0;
			sh_r   <= 10'h3ff;
			done_r <= 1'b0;
			ferr_r <= 1'b0;
		end else begin
			st_r   <= st_nxt;
			tcnt_r <= tcnt_nxt;
			bcnt_r <= bcnt_nxt;
			sh_r   <= sh_nxt;
			done_r <= done_nxt;
			ferr_r <= ferr_nxt;
		end
	end

	assign rx.done = done_r;
	assign rx.data = rx.nine ? sh_r[8:0] : {1'b0, sh_r[7:0]};
	assign rx.perr = ascs_parity(rx.data, rx.nine, rx.par_odd) != (rx.nine ? sh_r[9] : sh_r[8]); // R10
	assign rx.ferr = ferr_r;
endmodule
`default_nettype wire

// ---- verification/ascs_top_sva.sv ----
// port checker for the serial channel
`timescale 1ns/10ps
`default_nettype none
module ascs_top_sva
	import ascs_pkg::*;
(
	// clock and reset
	input wire logic              clk_in,
	input wire logic              arst_n_in,
	// register port
	input wire logic [ADDR_W-1:0] addr_in,
	input wire logic [DATA_W-1:0] wdata_in,
	input wire logic              wr_in,
	input wire logic              rd_in,
	input wire logic [DATA_W-1:0] rdata_out,
	// serial pins and interrupts
	input wire logic              rxd_in,
	input wire logic              txd_out,
	input wire logic              sclk_out,
	input wire logic [3:0]        irq_vec_out,
	input wire logic              irq_out
);
	logic [15:0] ctrl_r;
	logic [15:0] baud_r;
	logic [5:0]  mask_r;
	logic        async_w;
	logic        go_w;
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!arst_n_in);
	// shadow of the writable settings
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			ctrl_r <= CTRL_RST;
			baud_r <= BAUD_RST;
			mask_r <= MASK_RST;
		end else if (wr_in) begin
			if (addr_in == OFS_CTRL) ctrl_r <= wdata_in;
			if (addr_in == OFS_BAUD) baud_r <= wdata_in;
			if (addr_in == OFS_MASK) mask_r <= wdata_in[5:0];
		end
	end
	assign async_w = ctrl_r[1:0] != 2'b00;
	// only valid when the line is idle, which the bench guarantees
	assign go_w = wr_in && addr_in == OFS_TXD && async_w && baud_r == 16'h0000 && txd_out;
	property p_start;
		go_w |-> ##2 (!txd_out)[*8] ##1 (!txd_out)[*8];
	endproperty
	a_start: assert property (p_start) else $error("start bit not 16 clocks low");
	property p_lsb;
		logic [1:0] d;
		(go_w, d = wdata_in[1:0]) |-> ##18 txd_out == d[0] ##15 txd_out == d[0] ##1 txd_out == d[1];
	endproperty
	a_lsb: assert property (p_lsb) else $error("first data bits out of order");
	property p_tc;
		go_w && ctrl_r[3:0] == 4'h1 && mask_r[ST_TC] && !irq_vec_out[1] |-> ##[158:166] irq_vec_out[1];
	endproperty
	a_tc: assert property (p_tc) else $error("ten bit frame did not complete in time");
	property p_irq_or;
		irq_out == |irq_vec_out;
	endproperty
	a_irq_or: assert property (p_irq_or) else $error("interrupt line differs from vector");
	property p_mask;
		(irq_vec_out & ~{|mask_r[5:3], mask_r[2:0]}) == 4'h0;
	endproperty
	a_mask: assert property (p_mask) else $error("masked request raised");
	property p_rd_idle;
		!$past(rd_in) |-> rdata_out == 16'h0000;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
	property p_unmapped;
		rd_in && addr_in == 3'h7 |=> rdata_out == 16'h0000;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped index read nonzero");
	property p_sclk_async;
		async_w |-> sclk_out;
	endproperty
	a_sclk_async: assert property (p_sclk_async) else $error("shift clock moves in async mode");
	property p_sync_half;
		!async_w && baud_r == 16'h0000 && $fell(sclk_out) |=> $rose(sclk_out);
	endproperty
	a_sync_half: assert property (p_sync_half) else $error("shift clock low phase not one tick");
	c_tx: cover property (go_w);
	c_sync: cover property ($fell(sclk_out));
	c_err: cover property (irq_vec_out[3]);
endmodule
bind ascs_top ascs_top_sva chk_u (.clk_in(clk_in), .arst_n_in(arst_n_in), .addr_in(addr_in),
	.wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .rxd_in(rxd_in),
	.txd_out(txd_out), .sclk_out(sclk_out), .irq_vec_out(irq_vec_out), .irq_out(irq_out));
`default_nettype wire

// ---- verification/ascs_partner.sv ----
// remote serial terminal: async frames and sync bytes
`timescale 1ns/10ps
`default_nettype none
module ascs_partner (
	// clock and line side
	input  wire logic clk_in,
	input  wire logic txd_in,
	input  wire logic sclk_in,
	output logic      rxd_out
);
	initial rxd_out = 1'b1;
	// bits after the start bit, sampled mid bit
	task automatic arx(input int n, input int bt, output logic [15:0] f);
		f = 16'h0000;
		@(negedge txd_in);
		repeat (bt / 2) @(posedge clk_in);
		for (int i = 0; i < n; i++) begin
			repeat (bt) @(posedge clk_in);
			f[i] = txd_in;
		end
	endtask
	task automatic atx(input logic [15:0] f, input int n, input int bt);
		@(posedge clk_in);
		rxd_out <= 1'b0;
		for (int i = 0; i <= n; i++) begin
			repeat (bt) @(posedge clk_in);
			rxd_out <= (i == n) ? 1'b1 : f[i];
		end
		repeat (bt) @(posedge clk_in);
	endtask
	task automatic srx(output logic [7:0] d);
		for (int i = 0; i < 8; i++) begin
			@(posedge sclk_in);
			d[i] = txd_in;
		end
	endtask
	task automatic ssx(input logic [7:0] d);
		for (int i = 0; i < 8; i++) begin
			@(negedge sclk_in);
			rxd_out <= d[i];
		end
		@(posedge sclk_in);
		// released line shows no stale value
		rxd_out <= ~d[7];
		// back to the async idle level so a later frame sees no false start
		repeat (8) @(posedge clk_in);
		rxd_out <= 1'b1;
	endtask
endmodule
`default_nettype wire

// ---- verification/test_async_sync_serial_channel.sv ----
// self-checking bench for the serial channel
`timescale 1ns/10ps
`default_nettype none
module test_async_sync_serial_channel
	import ascs_pkg::*;
;
	logic        clk_in = 1'b0;
	logic        arst_n_in = 1'b0;
	logic [2:0]  addr_in;
	logic [15:0] wdata_in;
	logic        wr_in;
	logic        rd_in;
	logic [15:0] rdata_out;
	logic        rxd_w;
	logic        txd_w;
	logic        sclk_w;
	logic [3:0]  irq_vec;
	logic        irq;
	logic [15:0] f;
	logic [15:0] ex;
	logic [7:0]  b8;
	int          n;
	int          err_total;
	int          checks;
	logic [15:0] modes [3] = '{16'h0001, 16'h001e, 16'h0003};
	logic [8:0]  txv [3] = '{9'h0a7, 9'h15a, 9'h1c3};
	always #4 clk_in = ~clk_in;
	ascs_top dut_u (.clk_in(clk_in), .arst_n_in(arst_n_in), .addr_in(addr_in), .wdata_in(wdata_in),
		.wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .rxd_in(rxd_w), .txd_out(txd_w),
		.sclk_out(sclk_w), .irq_vec_out(irq_vec), .irq_out(irq));
	ascs_partner partner_u (.clk_in(clk_in), .txd_in(txd_w), .sclk_in(sclk_w), .rxd_out(rxd_w));
	task automatic cmp(input string nm, input logic [15:0] exp, input logic [15:0] got);
		checks++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic wr(input logic [2:0] a, input logic [15:0] d);
		@(posedge clk_in);
		wr_in <= 1'b1;
		addr_in <= a;
		wdata_in <= d;
		@(posedge clk_in);
		wr_in <= 1'b0;
	endtask
	task automatic rd(input logic [2:0] a, input logic [15:0] exp, input string nm);
		@(posedge clk_in);
		rd_in <= 1'b1;
		addr_in <= a;
		@(posedge clk_in);
		rd_in <= 1'b0;
		#1 cmp(nm, exp, rdata_out);
	endtask
	task automatic wait_vec(input int i);
		for (int k = 0; k < 600 && irq_vec[i] !== 1'b1; k++)
			@(posedge clk_in);
		#1 cmp("irq_vec", 16'h0001, {15'h0000, irq_vec[i]});
	endtask
	// expected line bits after the start bit
	function automatic logic [15:0] frame(input logic [15:0] c, input logic [8:0] d, output int k);
		logic p;
		frame = {8'h00, d[7:0]};
		p = ^d[7:0] ^ c[CTL_PAR_ODD];
		k = 8;
		if (c[1:0] != 2'b01) begin
			frame[k] = d[8];
			p = p ^ d[8];
			k++;
		end
		if (c[CTL_PAR_EN]) begin
			frame[k] = p;
			k++;
		end
		frame[k] = 1'b1;
		k = k + 1 + c[CTL_STOP2];
		frame[k-1] = 1'b1;
	endfunction
	task automatic conclude;
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	initial begin
		#(20000 * 8);
		err_total++;
		conclude();
	end
	initial begin
		wr_in = 1'b0;
		rd_in = 1'b0;
		addr_in = 3'h0;
		wdata_in = 16'h0000;
		err_total = 0;
		checks = 0;
		repeat (12) @(posedge clk_in);
		arst_n_in <= 1'b1;
		for (int a = 0; a < 8; a++) rd(a[2:0], 16'h0000, "reset");
		wr(OFS_MASK, 16'h003f);
		foreach (modes[i]) begin
			ex = frame(modes[i], txv[i], n);
			wr(OFS_CTRL, modes[i]);
			wr(OFS_STAT, 16'h003f);
			fork
				wr(OFS_TXD, {7'h00, txv[i]});
				partner_u.arx(n, 16, f);
			join
			cmp("tx frame", ex, f);
			wait_vec(1);
			rd(OFS_STAT, 16'h0003, "stat");
		end
		wr(OFS_MASK, 16'h0000);
		#1 cmp("irq masked", 16'h0000, {15'h0000, irq});
		wr(OFS_MASK, 16'h003f);
		#1 cmp("irq open", 16'h0001, {15'h0000, irq});
		wr(OFS_STAT, 16'h003f);
		#1 cmp("irq cleared", 16'h0000, {15'h0000, irq});
		// send and receive at once, then errors
		wr(OFS_CTRL, 16'h00a9);
		fork
			wr(OFS_TXD, 16'h0055);
			partner_u.arx(10, 16, f);
			partner_u.atx(16'h023c, 10, 16);
		join
		cmp("duplex tx", 16'h0255, f);
		wait_vec(2);
		rd(OFS_RXD, 16'h003c, "rx data");
		partner_u.atx(16'h023c, 10, 16);
		partner_u.atx(16'h0181, 10, 16);
		wait_vec(3);
		rd(OFS_STAT, 16'h003f, "rx errors");
		rd(OFS_STATE, 16'h0004, "state");
		rd(OFS_RXD, 16'h0081, "overrun data");
		wr(OFS_CTRL, 16'h00c1);
		wr(OFS_STAT, 16'h003f);
		wr(OFS_TXD, 16'h0069);
		wait_vec(2);
		rd(OFS_RXD, 16'h0069, "loopback");
		wr(OFS_CTRL, 16'h0000);
		wr(OFS_STAT, 16'h003f);
		fork
			wr(OFS_TXD, 16'h0096);
			partner_u.srx(b8);
		join
		cmp("sync tx", 16'h0096, {8'h00, b8});
		wait_vec(1);
		cmp("half duplex", 16'h0000, {15'h0000, irq_vec[2]});
		wr(OFS_BAUD, 16'h0003);
		fork
			wr(OFS_CTRL, 16'h0080);
			partner_u.ssx(8'hc5);
		join
		wait_vec(2);
		rd(OFS_RXD, 16'h00c5, "sync rx");
		rd(OFS_CTRL, 16'h0000, "rx enable");
		// sync loopback, then address filter in wake-bit mode
		wr(OFS_CTRL, 16'h0040);
		wr(OFS_STAT, 16'h003f);
		wr(OFS_TXD, 16'h00b4);
		wait_vec(2);
		rd(OFS_RXD, 16'h00b4, "sync loopback");
		wr(OFS_CTRL, 16'h0183);
		wr(OFS_STAT, 16'h003f);
		partner_u.atx(16'h0211, 10, 64);
		partner_u.atx(16'h03a5, 10, 64);
		wait_vec(2);
		rd(OFS_STAT, 16'h0004, "wake filter");
		rd(OFS_RXD, 16'h01a5, "wake address");
		conclude();
	end
endmodule
`default_nettype wire
